// [tb/acd_host_model.sv]
// Host CPU model that writes and reads the decoder's byte-wide port
`timescale 1ns/1ps
`default_nettype none

module acd_host_model
(
  input  wire logic              core_clk,
  input  wire logic              busy_n,  // Interface busy, low while busy
  input  wire logic [7:0]        rdata,   // Port read data
  output acd_pkg::acd_host_bus_type bus
);
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  initial bus = '{1'b1, 1'b1, 1'b1, 3'h0, 8'h00};

  // Strobe held past the sync stages; a released data bus shows the inverse value
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    bus <= '{1'b0, 1'b0, 1'b1, a, d};
    repeat (4) @(posedge core_clk);
    bus <= '{1'b1, 1'b1, 1'b1, a, ~d};
    repeat (3) @(posedge core_clk);
    n = 0;
    // Next access only once busy has ended, covers 12-cycle soft reset too
    while (busy_n !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    // A busy output that never frees the port counts against the run
    if (n == 40)
      tb_axis_command_decoder.bad_count++;
  endtask

  // Read held until the registered data has settled
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus <= '{1'b0, 1'b1, 1'b0, a, 8'h55};
    repeat (5) @(posedge core_clk);
    d = rdata;
    bus <= '{1'b1, 1'b1, 1'b1, a, 8'haa};
  endtask
endmodule // acd_host_model

`default_nettype wire

// [tb/tb_axis_command_decoder.sv]
// Self-checking bench of the axis command decoder
`timescale 1ns/1ps
`default_nettype none

module tb_axis_command_decoder;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic core_clk = 0, nrst = 0, clr = 0, dev_lvl = 1;
  logic [7:0] gpo_out = 8'h0f, rdata, gpo_level;
  logic [31:0] reg_rd = 32'hc3a5_1e87, reg_wdata;
  logic busy_n, oe, dev_out, rst_n, doe, wrq_n, ss_out, rw, rr;
  logic mv = 1, at_fl = 0, ss_en = 0;  // Motion qualifiers and shared stop enable of the axis
  logic [7:0] rsel;
  logic [2:0] pin_n = 3'h7;  // Emergency, start and latch pins, idle high
  acd_pkg::acd_host_bus_type bus;
  acd_pkg::acd_action_type act;
  logic [13:0] seen;  // Sticky record of pulses since last clear
  int bad_count = 0, n_tests = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  acd_host_model i_acd_host_model (.core_clk(core_clk), .busy_n(busy_n), .rdata(rdata), .bus(bus));
  // Open-drain shared stop wire pulled up unless driven
  acd_decoder i_acd_decoder (.core_clk(core_clk), .nrst(nrst), .host_bus(bus),
    .host_rdata(rdata), .host_data_oe(doe), .wait_request_out_n(wrq_n),
    .interface_busy_out_n(busy_n), .pins({pin_n[2], oe ? ss_out : 1'b1, pin_n[1:0]}),
    .shared_stop_pin_out(ss_out), .shared_stop_pin_oe(oe),
    .axis_moving(mv), .at_initial_speed(at_fl), .shared_stop_enable(ss_en),
    .dev_clear_level_type(dev_lvl), .gpo_is_output(gpo_out), .gpo_level(gpo_level),
    .deviation_clear_output(dev_out), .actions(act), .core_reset_n(rst_n), .reg_write(rw),
    .reg_read(rr), .reg_select(rsel), .reg_wdata(reg_wdata), .reg_rdata(reg_rd));
  // Action and register pulses last one cycle, so they are gathered here
  always @(posedge core_clk)
    seen <= clr ? 14'h0000 : seen | {~wrq_n, doe, rw, rr, ~rst_n, oe, act};
  // Hang guard
  always @(posedge core_clk) if (++cyc == 20000)
  begin
    bad_count++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic clear_seen();
    @(posedge core_clk) clr <= 1'b1;
    @(posedge core_clk) clr <= 1'b0;
  endtask
  // Axis byte always precedes the code
  task automatic cmd(input logic [7:0] c);
    i_acd_host_model.wr(3'h1, 8'h01);
    i_acd_host_model.wr(3'h0, c);
  endtask
  task automatic gpo8(input logic [7:0] base);
    for (int i = 0; i < 8; i++) cmd(base + 8'(i));
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_actions();
    logic [7:0] c [11] = '{8'h49, 8'h4a, 8'h05, 8'h07, 8'h20, 8'h21, 8'h26, 8'h28, 8'h29,
                           8'h00, 8'h3f};
    logic [9:0] e [11] = '{10'h080, 10'h040, 10'h020, 10'h100, 10'h010, 10'h008, 10'h004,
                           10'h002, 10'h001, 10'h000, 10'h000};
    for (int k = 0; k < 11; k++)
    begin
      clear_seen();
      cmd(c[k]);
      chk(32'(seen[9:0]), 32'(e[k]));
    end
  endtask
  // Pin paths, motion qualifiers and the shared stop loop back
  task automatic t_more();
    clear_seen();
    pin_n <= 3'h0;
    repeat (4) @(posedge core_clk);
    pin_n <= 3'h7;
    repeat (4) @(posedge core_clk);
    chk(32'(seen[9:0]), 32'h023);
    mv <= 1'b0;
    clear_seen();
    cmd(8'h49);
    chk(32'(seen[9:0]), 32'h000);
    mv <= 1'b1;
    at_fl <= 1'b1;
    clear_seen();
    cmd(8'h4a);
    chk(32'(seen[9:0]), 32'h080);
    ss_en <= 1'b1;
    clear_seen();
    cmd(8'h07);
    // The pin falling edge needs two sync stages before it stops the axis
    repeat (2) @(posedge core_clk);
    chk(32'(seen[9:0]), 32'h180);
    ss_en <= 1'b0;
    at_fl <= 1'b0;
  endtask
  task automatic t_gpo();
    gpo8(8'h18);
    chk(32'(gpo_level), 32'h0f);
    gpo8(8'h10);
    chk(32'(gpo_level), 32'h00);
    cmd(8'h1f);
    cmd(8'h18);
    chk(32'(gpo_level), 32'h01);
    gpo_out <= 8'h0e;
    cmd(8'h10);
    chk(32'(gpo_level), 32'h01);
    clear_seen();
    cmd(8'h04);
    chk(32'({seen[9], gpo_level}), 32'h100);
  endtask
  task automatic t_dev();
    cmd(8'h24);
    chk(32'(dev_out), 32'h1);
    cmd(8'h25);
    chk(32'(dev_out), 32'h0);
  endtask
  task automatic t_reg();
    logic [31:0] w = 32'h3c5a_96e1;
    logic [7:0] d;
    logic [7:0] sv [4];  // Buffer bytes saved as they are read back
    int ord [4] = '{7, 4, 6, 5};
    for (int k = 0; k < 4; k++)
      i_acd_host_model.wr(3'(ord[k]), w[8*(ord[k]-4) +: 8]);
    clear_seen();
    cmd(8'h90);
    chk(reg_wdata, w);
    chk(32'({seen[13:10], rsel}), 32'ha90);
    clear_seen();
    cmd(8'hd0);
    // Buffer bytes in scrambled order, back to back
    for (int k = 0; k < 4; k++)
    begin
      i_acd_host_model.rd(3'(ord[k]), sv[k]);
      chk(32'(sv[k]), 32'(reg_rd[8*(ord[k]-4) +: 8]));
    end
    chk(32'({seen[13:10], rsel}), 32'hdd0);
    i_acd_host_model.rd(3'h0, d);
    chk(32'(d), 32'h0);
    // A borrowed buffer is put back before the next register write
    i_acd_host_model.wr(3'h4, 8'h00);
    for (int k = 0; k < 4; k++)
      i_acd_host_model.wr(3'(ord[k]), sv[k]);
    cmd(8'h90);
    chk(reg_wdata, reg_rd);
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_actions();
    t_more();
    t_gpo();
    t_dev();
    t_reg();
    wrap_up();
  end
endmodule // tb_axis_command_decoder

`default_nettype wire

// [verilog/acd_decoder.sv]
// Command decoder of one pulse-control axis: stop, control, output and transfer
`timescale 1ns/1ps
`default_nettype none

module acd_decoder
#(
  parameter int AXIS_INDEX = 0  // Bit of the axis select byte for this axis
)
(
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire acd_pkg::acd_host_bus_type host_bus,
  output logic                    [7:0]  host_rdata,
  output logic                           host_data_oe,
  output logic                           wait_request_out_n,
  output logic                           interface_busy_out_n,
  input  wire acd_pkg::acd_pin_type      pins,
  output logic                           shared_stop_pin_out,
  output logic                           shared_stop_pin_oe,
  input  wire logic                      axis_moving,
  input  wire logic                      at_initial_speed,
  input  wire logic                      shared_stop_enable,
  input  wire logic                      dev_clear_level_type,
  input  wire logic               [7:0]  gpo_is_output,
  output logic                    [7:0]  gpo_level,
  output logic                           deviation_clear_output,
  output acd_pkg::acd_action_type        actions,
  output logic                           core_reset_n,
  output logic                           reg_write,
  output logic                           reg_read,
  output logic                    [7:0]  reg_select,
  output logic                   [31:0]  reg_wdata,
  input  wire logic              [31:0]  reg_rdata
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  acd_pkg::acd_host_bus_type host_s;       // Synchronised host bus
  acd_pkg::acd_pin_type      pins_s;       // Synchronised pins
  acd_pkg::acd_pin_type      pins_d;       // Pins one cycle later
  acd_pkg::acd_state_type    state;        // Sequencer state
  acd_pkg::acd_action_type   next_actions; // Pulses for the next cycle
  logic                      wr_n_d;       // Previous write strobe
  logic                      wr_evt;       // Write strobe falling edge
  logic                      accept;       // Write taken this cycle
  logic                      cmd_accept;   // Command byte taken
  logic                      soft_reset_cmd_accept;  // Soft reset command taken
  logic                [7:0] cmd_code;     // Command being processed
  logic                [7:0] axis_sel;     // Axis select byte
  logic               [31:0] iobuf;        // I/O buffer, four bytes
  logic                [3:0] busy_cnt;     // Remaining busy cycles
  logic                [3:0] next_busy_cnt;
  logic                [3:0] soft_reset_cmd_cnt;     // Soft reset in progress
  logic                [3:0] ss_cnt;       // Shared stop pulse cycles
  logic                [3:0] dev_cnt;      // Deviation clear pulse cycles
  logic                      core_rst;     // Pin or soft reset
  logic                      dec;          // Decoding this cycle
  logic                [7:0] gpo_set;      // Per-bit high commands
  logic                [7:0] gpo_clr;      // Per-bit low commands

  assign core_rst = !nrst || (soft_reset_cmd_cnt != 4'h0);
  assign dec      = (state == acd_pkg::ST_DECODE);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Data passes the same two stages as the strobes, so the host must
  // hold it stable around the strobe edge
  acd_sync #(.W($bits(acd_pkg::acd_host_bus_type)), .IDLE(14'h3800)) u_bus_sync
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .d        (host_bus),
    .q        (host_s)
  );

  acd_sync #(.W($bits(acd_pkg::acd_pin_type)), .IDLE(4'hf)) u_pin_sync
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .d        (pins),
    .q        (pins_s)
  );

  // Edge history of the synchronised write strobe and pins
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wr_n_d <= 1'b1;
      pins_d <= 4'hf;
    end
    else
    begin
      wr_n_d <= host_s.wr_n;
      pins_d <= pins_s;
    end
  end

  assign wr_evt = !host_s.cs_n && !host_s.wr_n && wr_n_d;
  // Writes inside the busy interval are dropped; a held-off host never makes them
  assign accept      = wr_evt && (busy_cnt == 4'h0) && (state == acd_pkg::ST_IDLE);
  assign cmd_accept  = accept && (host_s.addr == acd_pkg::ADDR_CMD_CODE);
  assign soft_reset_cmd_accept = cmd_accept && axis_sel[AXIS_INDEX]
                       && (host_s.wdata == acd_pkg::CMD_SOFT_RESET);

  // ---------------------------------------------------------------
  // Soft reset timer
  // ---------------------------------------------------------------
  // Only the pin clears it, so the soft reset always runs its full length
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      soft_reset_cmd_cnt <= 4'h0;
    else if (soft_reset_cmd_accept)
      soft_reset_cmd_cnt <= acd_pkg::SOFT_RESET_CMD_CYCLES;
    else if (soft_reset_cmd_cnt != 4'h0)
      soft_reset_cmd_cnt <= soft_reset_cmd_cnt - 4'h1;
  end

  // ---------------------------------------------------------------
  // Busy interval and host hold-off
  // ---------------------------------------------------------------
  always_comb
  begin
    next_busy_cnt = busy_cnt;
    if (soft_reset_cmd_accept)
      next_busy_cnt = acd_pkg::SOFT_RESET_CMD_CYCLES;
    else if (cmd_accept)
      next_busy_cnt = acd_pkg::CMD_BUSY_CYCLES;
    else if (accept)
      next_busy_cnt = acd_pkg::BUF_BUSY_CYCLES;
    else if (busy_cnt != 4'h0)
      next_busy_cnt = busy_cnt - 4'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      busy_cnt             <= 4'h0;
      interface_busy_out_n <= 1'b1;
      wait_request_out_n   <= 1'b1;
    end
    else
    begin
      busy_cnt             <= next_busy_cnt;
      interface_busy_out_n <= (next_busy_cnt == 4'h0);
      wait_request_out_n   <= !(!host_s.cs_n && next_busy_cnt != 4'h0);
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and host write capture
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (core_rst)
    begin
      state    <= acd_pkg::ST_IDLE;
      cmd_code <= acd_pkg::CMD_NOP;
      axis_sel <= 8'h00;
      iobuf    <= 32'h0000_0000;
    end
    else
    begin
      case (state)
        acd_pkg::ST_IDLE:
        begin
          if (accept && host_s.addr == acd_pkg::ADDR_AXIS_SEL)
            axis_sel <= host_s.wdata;
          else if (accept && host_s.addr[2])
            iobuf[8*host_s.addr[1:0] +: 8] <= host_s.wdata;  // Any byte order
          if (cmd_accept && axis_sel[AXIS_INDEX])
          begin
            cmd_code <= host_s.wdata;
            state    <= acd_pkg::ST_DECODE;
          end
        end
        acd_pkg::ST_DECODE:
        begin
          if (cmd_code[7:6] == acd_pkg::CMD_REG_READ)
            state <= acd_pkg::ST_FETCH;
          else
            state <= acd_pkg::ST_HOLD;
        end
        acd_pkg::ST_FETCH:
        begin
          iobuf <= reg_rdata;
          state <= acd_pkg::ST_HOLD;
        end
        acd_pkg::ST_HOLD:
        begin
          if (busy_cnt <= 4'h1)
            state <= acd_pkg::ST_IDLE;
        end
        default:
          state <= acd_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register transfer requests
  // ---------------------------------------------------------------
  // The register side answers a read in the same cycle as reg_read
  always_ff @(posedge core_clk)
  begin
    if (core_rst)
    begin
      reg_write  <= 1'b0;
      reg_read   <= 1'b0;
      reg_select <= 8'h00;
      reg_wdata  <= 32'h0000_0000;
    end
    else
    begin
      reg_write <= dec && (cmd_code[7:6] == acd_pkg::CMD_REG_WRITE);
      reg_read  <= dec && (cmd_code[7:6] == acd_pkg::CMD_REG_READ);
      if (dec)
      begin
        reg_select <= cmd_code;
        reg_wdata  <= iobuf;
      end
    end
  end

  // ---------------------------------------------------------------
  // Buffer read port
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (core_rst)
    begin
      host_rdata   <= 8'h00;
      host_data_oe <= 1'b0;
    end
    else
    begin
      host_data_oe <= !host_s.cs_n && !host_s.rd_n && host_s.addr[2];
      if (host_s.addr[2])
        host_rdata <= iobuf[8*host_s.addr[1:0] +: 8];
      else
        host_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Action pulses
  // ---------------------------------------------------------------
  // Unlisted codes take the default branch and raise nothing
  always_comb
  begin
    next_actions = '0;
    if (dec)
    begin
      case (cmd_code)
        acd_pkg::CMD_STOP_NOW:
          next_actions.immediate_stop = axis_moving;
        acd_pkg::CMD_STOP_DECEL:
        begin
          next_actions.decel_stop     = axis_moving && !at_initial_speed;
          next_actions.immediate_stop = axis_moving && at_initial_speed;
        end
        acd_pkg::CMD_EMERGENCY:  next_actions.emergency_halt = 1'b1;
        acd_pkg::CMD_CNT1_CLEAR: next_actions.command_counter_clear = 1'b1;
        acd_pkg::CMD_CNT2_CLEAR: next_actions.mechanical_counter_clear = 1'b1;
        acd_pkg::CMD_QUEUE_CAN:  next_actions.queue_cancel = 1'b1;
        acd_pkg::CMD_START_SUB:  next_actions.positioning_start = 1'b1;
        acd_pkg::CMD_LATCH_SUB:  next_actions.counter_latch = 1'b1;
        default:                 next_actions = '0;
      endcase
    end
    // Pin paths share the same outputs as their command substitutes
    if (!pins_s.emergency_n)
      next_actions.emergency_halt = 1'b1;
    if (!pins_s.shared_n && pins_d.shared_n && shared_stop_enable && axis_moving)
      next_actions.immediate_stop = 1'b1;
    if (!pins_s.start_n && pins_d.start_n)
      next_actions.positioning_start = 1'b1;
    if (!pins_s.latch_n && pins_d.latch_n)
      next_actions.counter_latch = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (core_rst)
      actions <= '0;
    else
      actions <= next_actions;
  end

  // ---------------------------------------------------------------
  // Shared stop one-shot, open drain
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (core_rst)
      ss_cnt <= 4'h0;
    else if (dec && cmd_code == acd_pkg::CMD_SHARED_STOP)
      ss_cnt <= acd_pkg::STOP_PULSE_CYCLES;
    else if (ss_cnt != 4'h0)
      ss_cnt <= ss_cnt - 4'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (core_rst)
    begin
      shared_stop_pin_out <= 1'b0;
      shared_stop_pin_oe  <= 1'b0;
    end
    else
    begin
      shared_stop_pin_out <= 1'b0;  // Only ever pulls low
      shared_stop_pin_oe  <= (dec && cmd_code == acd_pkg::CMD_SHARED_STOP) || ss_cnt > 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Deviation clear output
  // ---------------------------------------------------------------
  // Pulse type ends on its own timer; release command is ignored then
  always_ff @(posedge core_clk)
  begin
    if (core_rst)
    begin
      deviation_clear_output <= 1'b0;
      dev_cnt                <= 4'h0;
    end
    else if (dec && cmd_code == acd_pkg::CMD_DEV_ASSERT)
    begin
      deviation_clear_output <= 1'b1;
      dev_cnt                <= acd_pkg::DEV_PULSE_CYCLES;
    end
    else if (dec && cmd_code == acd_pkg::CMD_DEV_RELEASE && dev_clear_level_type)
      deviation_clear_output <= 1'b0;
    else if (!dev_clear_level_type && dev_cnt != 4'h0)
    begin
      dev_cnt <= dev_cnt - 4'h1;
      if (dev_cnt == 4'h1)
        deviation_clear_output <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // General-purpose output bits
  // ---------------------------------------------------------------
  always_comb
  begin
    gpo_set = 8'h00;
    gpo_clr = 8'h00;
    if (dec && cmd_code[7:3] == acd_pkg::CMD_GPO_HIGH[7:3])
      gpo_set[cmd_code[2:0]] = 1'b1;
    if (dec && cmd_code[7:3] == acd_pkg::CMD_GPO_LOW[7:3])
      gpo_clr[cmd_code[2:0]] = 1'b1;
  end

  for (genvar i = 0; i < 8; i++)
  begin : g_gpo
    acd_gpo_bit u_bit
    (
      .core_clk  (core_clk),
      .nrst      (!core_rst),
      .set_high  (gpo_set[i]),
      .set_low   (gpo_clr[i]),
      .is_output (gpo_is_output[i]),
      .level     (gpo_level[i])
    );
  end

  always_ff @(posedge core_clk)
  begin
    core_reset_n <= !core_rst;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (core_rst);

  stop_now_a: assert property (dec && cmd_code == 8'h49 && axis_moving |=> actions.immediate_stop)
    else $error("immediate stop not raised");
  decel_stop_a: assert property (dec && cmd_code == 8'h4a && axis_moving && !at_initial_speed
    |=> actions.decel_stop && !actions.immediate_stop)
    else $error("deceleration stop wrong");
  shared_pulse_a: assert property (dec && cmd_code == 8'h07 |=> shared_stop_pin_oe[*4]
    ##1 !shared_stop_pin_oe)
    else $error("shared stop pulse width wrong");
  emergency_cmd_a: assert property (dec && cmd_code == 8'h05 |=> actions.emergency_halt)
    else $error("emergency halt not raised");
  gpo_ignore_a: assert property (!gpo_is_output[0] |=> $stable(gpo_level[0]))
    else $error("non-output pin changed");
  gpo_set_a: assert property (dec && cmd_code == 8'h18 && gpo_is_output[0] |=> gpo_level[0])
    else $error("output 0 not set high");
  busy_span_a: assert property (disable iff (!nrst) cmd_accept && !soft_reset_cmd_accept
    |=> !interface_busy_out_n[*4] ##1 interface_busy_out_n)
    else $error("busy interval not four cycles");
  fetch_copy_a: assert property (state == acd_pkg::ST_FETCH |=> iobuf == $past(reg_rdata))
    else $error("read data not copied to buffer");
  dev_release_a: assert property (dec && cmd_code == 8'h25 && dev_clear_level_type
    |=> !deviation_clear_output)
    else $error("deviation clear not released");
  wait_busy_a: assert property (disable iff (!nrst) !wait_request_out_n |-> !interface_busy_out_n)
    else $error("wait request outside busy");

endmodule // acd_decoder

`default_nettype wire

// [verilog/acd_gpo_bit.sv]
// One general-purpose output level with bit set and clear
`timescale 1ns/1ps
`default_nettype none

module acd_gpo_bit
(
  input  wire logic core_clk,
  input  wire logic nrst,       // Includes soft reset
  input  wire logic set_high,   // One-cycle set command
  input  wire logic set_low,    // One-cycle clear command
  input  wire logic is_output,  // Pin configured as output
  output logic      level
);

  // ---------------------------------------------------------------
  // Output latch
  // ---------------------------------------------------------------
  // Level is kept when the pin turns to input, so it returns intact
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      level <= 1'b0;
    else if (is_output && set_high)
      level <= 1'b1;
    else if (is_output && set_low)
      level <= 1'b0;
  end

endmodule // acd_gpo_bit

`default_nettype wire

// [verilog/acd_pkg.sv]
// Constants, codes and carrier types of the axis command decoder
//
// Summary of operation
// - Immediate stop code halts a moving axis
// - Decelerating stop ramps down, else stops immediately
// - Shared stop code pulses shared stop pin
// - Emergency code acts like emergency halt pin
// - No-operation code changes nothing
// - Codes drive general outputs low or high
// - Output commands ignored on non-output pins
// - Soft reset code equals reset pin
// - Clear codes zero command and mechanical counters
// - Deviation clear asserts; release only level type
// - Queue cancel code discards queued operation data
// - Start substitute acts like positioning start pulse
// - Latch substitute acts like counter latch input
// - Register commands copy between buffer and register
// - Read data reaches buffer within four cycles
// - Buffer bytes read in any order, unspaced
// - Wait request holds host off while busy
// - Busy output low while a command runs
package acd_pkg;

  // ---------------------------------------------------------------
  // Host port addresses
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_CMD_CODE   = 3'h0; // Command code byte
  localparam logic [2:0] ADDR_AXIS_SEL   = 3'h1; // Axis select byte

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_NOP         = 8'h00;
  localparam logic [7:0] CMD_SOFT_RESET  = 8'h04;
  localparam logic [7:0] CMD_EMERGENCY   = 8'h05;
  localparam logic [7:0] CMD_SHARED_STOP = 8'h07;
  localparam logic [7:0] CMD_GPO_LOW     = 8'h10; // 10h..17h: outputs 0..7 low
  localparam logic [7:0] CMD_GPO_HIGH    = 8'h18; // 18h..1Fh: outputs 0..7 high
  localparam logic [7:0] CMD_CNT1_CLEAR  = 8'h20;
  localparam logic [7:0] CMD_CNT2_CLEAR  = 8'h21;
  localparam logic [7:0] CMD_DEV_ASSERT  = 8'h24;
  localparam logic [7:0] CMD_DEV_RELEASE = 8'h25;
  localparam logic [7:0] CMD_QUEUE_CAN   = 8'h26;
  localparam logic [7:0] CMD_START_SUB   = 8'h28;
  localparam logic [7:0] CMD_LATCH_SUB   = 8'h29;
  localparam logic [7:0] CMD_STOP_NOW    = 8'h49;
  localparam logic [7:0] CMD_STOP_DECEL  = 8'h4a;
  localparam logic [1:0] CMD_REG_WRITE   = 2'h2; // Top bits of 80h..BFh
  localparam logic [1:0] CMD_REG_READ    = 2'h3; // Top bits of C0h..FFh

  // ---------------------------------------------------------------
  // Timing counts in reference clock cycles
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_BUSY_CYCLES  = 4'h4; // After a command write
  localparam logic [3:0] BUF_BUSY_CYCLES  = 4'h2; // After a buffer write
  localparam logic [3:0] SOFT_RESET_CMD_CYCLES      = 4'hc; // Soft reset duration
  localparam logic [3:0] STOP_PULSE_CYCLES = 4'h4; // Shared stop one-shot
  localparam logic [3:0] DEV_PULSE_CYCLES = 4'h4; // Pulse-type deviation clear

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic       cs_n;   // Chip select, active low
    logic       wr_n;   // Write strobe, active low
    logic       rd_n;   // Read strobe, active low
    logic [2:0] addr;   // Byte address
    logic [7:0] wdata;  // Write data
  } acd_host_bus_type;

  typedef struct packed
  {
    logic emergency_n;  // Emergency halt pin
    logic shared_n;     // Shared stop pin, read back
    logic start_n;      // Positioning start pin
    logic latch_n;      // Counter latch pin
  } acd_pin_type;

  typedef struct packed
  {
    logic immediate_stop;
    logic decel_stop;
    logic emergency_halt;
    logic command_counter_clear;
    logic mechanical_counter_clear;
    logic queue_cancel;
    logic positioning_start;
    logic counter_latch;
  } acd_action_type;

  typedef enum logic [3:0]
  {
    ST_IDLE   = 4'b0001,  // Waiting for a host write
    ST_DECODE = 4'b0010,  // Acting on the command code
    ST_FETCH  = 4'b0100,  // Capturing register read data
    ST_HOLD   = 4'b1000   // Waiting out the busy interval
  } acd_state_type;

endpackage

// [verilog/acd_sync.sv]
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module acd_sync
#(
  parameter int           W       = 1,
  parameter logic [W-1:0] IDLE    = '1  // Level the pins rest at
)
(
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // First stage, read only by the second
  logic [W-1:0] meta;

  // ---------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      meta <= IDLE;
      q    <= IDLE;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // acd_sync

`default_nettype wire
